// ===== hw/sba_slave.sv
// Two-wire bus slave with strapped address, register pointer and alert line.
//
// Summary of operation
// - Address comes from three address pins, each low, high or open.
// - Top two address bits are fixed at binary 10.
// - Writes to the shared mass-write address are accepted too.
// - Mass-write enable low stops answering the mass-write address.
// - While alerting, answer alert response with own address, then release.
// - Each strap combination maps to its tabulated address.
// - Only the low three command bits load the register pointer.
// - First data byte of a write is acknowledged and stored.
// - A second written data byte is acknowledged but discarded.
// - Read uses repeated start with read bit; device acks and sends data.
// - When master acks a read byte, the same register is sent again.
// - Transmitter releases data line during the acknowledge clock.
// - Receiving device holds data low through its acknowledge clock.
// - Alert goes low when an enabled fault flag becomes set.
// - Alert response returns own address then zero; master does not ack.
// - Being addressed directly also releases the alert line.
// - Released alert waits for a new rising enabled fault flag.
// - Start is data falling with clock high; stop is data rising.
`timescale 1ns/100ps
module sba_slave #(
  parameter int FAULT_W = sba_pkg::FAULT_W
) (
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Bus clock and open-drain data line.
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Open-drain alert line.
  output logic alert_out,
  output logic alert_oe_out,
  // Address-select straps.
  input wire logic [1:0] addr_select_pin_0_in,
  input wire logic [1:0] addr_select_pin_1_in,
  input wire logic [1:0] addr_select_pin_2_in,
  // Control and fault inputs from the register file.
  input wire logic mass_write_enable_bit_in,
  input wire logic [FAULT_W-1:0] fault_flags_in,
  input wire logic [FAULT_W-1:0] alert_enable_in,
  // Register access port.
  output sba_pkg::sba_wr_type reg_wr_out,
  output logic [sba_pkg::PTR_W-1:0] reg_rd_addr_out,
  input wire logic [sba_pkg::BYTE_W-1:0] reg_rd_data_in,
  // Status.
  output logic [6:0] own_addr_out
);
  import sba_pkg::*;

  if (FAULT_W < 1 || FAULT_W > BYTE_W) begin : g_chk
    $error("FAULT_W must lie between 1 and 8");
  end

  typedef struct packed {
    sba_state_type state;
    logic [BYTE_W-1:0] shift;
    logic [3:0] cnt;
    logic [1:0] idx;
    logic rw;
    logic ara;
    logic ack_seen;
    logic sda_oe;
    logic [PTR_W-1:0] ptr;
    logic alert;
    logic [FAULT_W-1:0] armed_prev;
    sba_wr_type wr;
    logic [5:0] strap_m;
    logic [5:0] strap_s;
  } sba_main_st_type;

  localparam sba_main_st_type RESET_ST = '{state: ST_IDLE, default: '0};

  sba_main_st_type st_q;
  sba_main_st_type st_d;
  sba_bus_ev_type ev;
  logic [6:0] own_addr;
  logic [FAULT_W-1:0] armed;
  logic new_fault;
  logic release_alert;
  logic byte_end;
  logic addr_end;
  logic cmd_end;
  logic data_end;
  logic extra_end;
  logic [6:0] addr_field;
  logic hit_own;
  logic hit_mw;
  logic hit_ara;
  logic [PTR_W-1:0] shift_lo;

  sba_bus_cond u_cond (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ev_out(ev)
  );

  sba_addr_decode u_dec (
    .strap_in(st_q.strap_s),
    .addr_out(own_addr)
  );

  assign addr_field = st_q.shift[BYTE_W-1:1];
  assign shift_lo = st_q.shift[PTR_W-1:0];
  assign byte_end = (st_q.state == ST_RX) && ev.scl_fall &&
                    (st_q.cnt == BITS_PER_BYTE) && !ev.start && !ev.stop;
  assign addr_end = byte_end && (st_q.idx == IDX_ADDR);
  assign cmd_end = byte_end && (st_q.idx == IDX_CMD);
  assign data_end = byte_end && (st_q.idx == IDX_DATA);
  assign extra_end = byte_end && (st_q.idx == IDX_EXTRA);
  assign hit_own = (addr_field == own_addr);
  assign hit_mw = (addr_field == MASS_WRITE_ADDR) &&
                  mass_write_enable_bit_in && !st_q.shift[0];
  assign hit_ara = (addr_field == ALERT_RESP_ADDR) && st_q.alert &&
                   st_q.shift[0];
  assign armed = fault_flags_in & alert_enable_in;
  assign new_fault = |(armed & ~st_q.armed_prev);

  always_comb begin
    st_d = st_q;
    release_alert = 1'b0;
    st_d.wr.strobe = 1'b0;
    st_d.strap_m = {addr_select_pin_2_in, addr_select_pin_1_in,
                    addr_select_pin_0_in};
    st_d.strap_s = st_q.strap_m;
    st_d.armed_prev = armed;
    case (st_q.state)
      ST_IDLE: begin
        st_d.sda_oe = 1'b0;
      end
      ST_RX: begin
        if (ev.scl_rise && st_q.cnt != BITS_PER_BYTE) begin
          st_d.shift = {st_q.shift[BYTE_W-2:0], ev.sda};
          st_d.cnt = st_q.cnt + 4'h1;
        end
        if (addr_end) begin
          if (hit_own || hit_mw || hit_ara) begin
            st_d.state = ST_ACK;
            st_d.sda_oe = 1'b1;
            st_d.rw = st_q.shift[0];
            st_d.ara = hit_ara;
          end else begin
            st_d.state = ST_WAIT;
          end
          if (hit_own) begin
            release_alert = 1'b1;
          end
        end else if (byte_end) begin
          st_d.state = ST_ACK;
          st_d.sda_oe = 1'b1;
        end
        if (cmd_end) begin
          st_d.ptr = shift_lo;
        end
        if (data_end) begin
          st_d.wr.strobe = 1'b1;
          st_d.wr.addr = st_q.ptr;
          st_d.wr.data = st_q.shift;
        end
      end
      ST_ACK: begin
        if (ev.scl_fall) begin
          st_d.cnt = 4'h0;
          if (st_q.rw) begin
            st_d.state = ST_TX;
            st_d.shift = st_q.ara ? {own_addr, 1'b0} : reg_rd_data_in;
            st_d.sda_oe = st_q.ara ? !own_addr[6] : !reg_rd_data_in[7];
          end else begin
            st_d.state = ST_RX;
            st_d.sda_oe = 1'b0;
            if (st_q.idx != IDX_EXTRA) begin
              st_d.idx = st_q.idx + 2'h1;
            end
          end
        end
      end
      ST_TX: begin
        if (ev.scl_fall) begin
          if (st_q.cnt == LAST_TX_BIT) begin
            st_d.state = ST_TXACK;
            st_d.sda_oe = 1'b0;
            st_d.ack_seen = 1'b0;
          end else begin
            st_d.shift = {st_q.shift[BYTE_W-2:0], 1'b0};
            st_d.sda_oe = !st_q.shift[BYTE_W-2];
            st_d.cnt = st_q.cnt + 4'h1;
          end
        end
      end
      ST_TXACK: begin
        if (ev.scl_rise) begin
          st_d.ack_seen = !ev.sda;
        end
        if (ev.scl_fall) begin
          st_d.cnt = 4'h0;
          if (st_q.ara) begin
            release_alert = 1'b1;
            st_d.state = ST_WAIT;
          end else if (st_q.ack_seen) begin
            st_d.state = ST_TX;
            st_d.shift = reg_rd_data_in;
            st_d.sda_oe = !reg_rd_data_in[7];
          end else begin
            st_d.state = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        st_d.sda_oe = 1'b0;
      end
      default: begin
        st_d.state = ST_IDLE;
        st_d.sda_oe = 1'b0;
      end
    endcase
    if (ev.stop) begin
      st_d.state = ST_IDLE;
      st_d.sda_oe = 1'b0;
    end
    if (ev.start) begin
      st_d.state = ST_RX;
      st_d.cnt = 4'h0;
      st_d.idx = IDX_ADDR;
      st_d.sda_oe = 1'b0;
      st_d.ara = 1'b0;
      st_d.rw = 1'b0;
    end
    if (release_alert) begin
      st_d.alert = 1'b0;
    end
    if (new_fault) begin
      st_d.alert = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      st_q <= RESET_ST;
    end else begin
      st_q <= st_d;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_out = st_q.sda_oe;
  assign alert_out = 1'b0;
  assign alert_oe_out = st_q.alert;
  assign reg_wr_out = st_q.wr;
  assign reg_rd_addr_out = st_q.ptr;
  assign own_addr_out = own_addr;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);

  sequence s_acked_read;
    (st_q.state == ST_TXACK) && ev.scl_fall && st_q.ack_seen &&
      !st_q.ara && !ev.start && !ev.stop;
  endsequence

  sequence s_ara_load;
    (st_q.state == ST_ACK) && ev.scl_fall && st_q.ara && st_q.rw &&
      !ev.start && !ev.stop;
  endsequence

  property p_ptr_low;
    cmd_end |=> (reg_rd_addr_out == $past(shift_lo));
  endproperty
  a_ptr_low: assert property (p_ptr_low)
    else $error("pointer not loaded from low command bits");

  property p_store;
    data_end |=> reg_wr_out.strobe && (reg_wr_out.addr == $past(st_q.ptr));
  endproperty
  a_store: assert property (p_store)
    else $error("data byte not stored at pointer");

  property p_discard;
    extra_end |=> !reg_wr_out.strobe && (st_q.idx == IDX_EXTRA) ##1
      !reg_wr_out.strobe;
  endproperty
  a_discard: assert property (p_discard)
    else $error("second data byte was written");

  property p_ack_low;
    (st_q.state == ST_ACK) |-> sda_oe_out;
  endproperty
  a_ack_low: assert property (p_ack_low)
    else $error("data line not held low in acknowledge");

  property p_tx_release;
    (st_q.state == ST_TXACK) |-> !sda_oe_out;
  endproperty
  a_tx_release: assert property (p_tx_release)
    else $error("data line driven in master acknowledge");

  property p_alert_set;
    new_fault |=> alert_oe_out [*2] or (alert_oe_out ##1 1'b1);
  endproperty
  a_alert_set: assert property (p_alert_set)
    else $error("alert not raised on new enabled fault");

  property p_direct_release;
    (addr_end && hit_own && !new_fault) |=> !alert_oe_out;
  endproperty
  a_direct_release: assert property (p_direct_release)
    else $error("alert kept after direct address");

  property p_no_hit;
    (addr_end && !hit_own && !hit_mw && !hit_ara) |=>
      (st_q.state == ST_WAIT) && !sda_oe_out;
  endproperty
  a_no_hit: assert property (p_no_hit)
    else $error("unmatched or mass-write read acknowledged");

  property p_start;
    ev.start |=> (st_q.state == ST_RX) && (st_q.cnt == 4'h0) && !sda_oe_out;
  endproperty
  a_start: assert property (p_start)
    else $error("start did not restart address reception");

  property p_word_read;
    s_acked_read |=> (st_q.state == ST_TX) &&
      (st_q.shift == $past(reg_rd_data_in));
  endproperty
  a_word_read: assert property (p_word_read)
    else $error("acked read byte not repeated");

  property p_ara_addr;
    s_ara_load |=> (st_q.shift == {own_addr, 1'b0}) && alert_oe_out;
  endproperty
  a_ara_addr: assert property (p_ara_addr)
    else $error("alert response did not load own address");

  property p_no_retrigger;
    (!new_fault && !alert_oe_out) |=> !alert_oe_out;
  endproperty
  a_no_retrigger: assert property (p_no_retrigger)
    else $error("alert rose without a new fault");

endmodule

// ===== hw/sba_pkg.sv
// Shared constants and carrier types for the bus slave with alert.
package sba_pkg;

  // Fixed upper address bits and the two special addresses.
  localparam logic [1:0] ADDR_TOP = 2'h2;
  localparam logic [6:0] MASS_WRITE_ADDR = 7'h5f;
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;

  // Strap level codes on each address-select pin.
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_HIGH = 2'h1;
  localparam logic [1:0] STRAP_OPEN = 2'h2;

  // Byte framing.
  localparam int BYTE_W = 8;
  localparam int PTR_W = 3;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;

  // Byte position within a transaction.
  localparam logic [1:0] IDX_ADDR = 2'h0;
  localparam logic [1:0] IDX_CMD = 2'h1;
  localparam logic [1:0] IDX_DATA = 2'h2;
  localparam logic [1:0] IDX_EXTRA = 2'h3;

  // Default count of fault flags and alert enables.
  localparam int FAULT_W = 6;

  // Bus conditions seen on the synchronised clock and data lines.
  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic sda;
  } sba_bus_ev_type;

  // Register write port towards the register file.
  typedef struct packed {
    logic strobe;
    logic [PTR_W-1:0] addr;
    logic [BYTE_W-1:0] data;
  } sba_wr_type;

  // Transaction states, one-hot.
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_RX    = 6'h02,
    ST_ACK   = 6'h04,
    ST_TX    = 6'h08,
    ST_TXACK = 6'h10,
    ST_WAIT  = 6'h20
  } sba_state_type;

endpackage

// ===== hw/sba_bus_cond.sv
// Synchroniser and start, stop and clock-edge detector for the bus lines.
`timescale 1ns/100ps
module sba_bus_cond (
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Bus lines.
  input wire logic scl_in,
  input wire logic sda_in,
  // Detected conditions.
  output sba_pkg::sba_bus_ev_type ev_out
);
  import sba_pkg::*;

  typedef struct packed {
    logic scl_m;
    logic sda_m;
    logic scl_s;
    logic sda_s;
    logic scl_p;
    logic sda_p;
  } sba_cond_st_type;

  sba_cond_st_type st_q;
  sba_cond_st_type st_d;

  always_comb begin
    st_d = st_q;
    st_d.scl_m = scl_in;
    st_d.sda_m = sda_in;
    st_d.scl_s = st_q.scl_m;
    st_d.sda_s = st_q.sda_m;
    st_d.scl_p = st_q.scl_s;
    st_d.sda_p = st_q.sda_s;
  end

  // Idle bus is high on both lines.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      st_q <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  assign ev_out = '{
    start: st_q.scl_s & st_q.scl_p & st_q.sda_p & ~st_q.sda_s,
    stop: st_q.scl_s & st_q.scl_p & ~st_q.sda_p & st_q.sda_s,
    scl_rise: st_q.scl_s & ~st_q.scl_p,
    scl_fall: ~st_q.scl_s & st_q.scl_p,
    sda: st_q.sda_s
  };

endmodule

// ===== hw/sba_addr_decode.sv
// Decodes the three address-select straps into the seven-bit slave address.
`timescale 1ns/100ps
module sba_addr_decode (
  // Synchronised strap codes, pin 2 down to pin 0.
  input wire logic [5:0] strap_in,
  // Slave address.
  output logic [6:0] addr_out
);
  import sba_pkg::*;

  function automatic logic [4:0] strap_index(input logic [5:0] s);
    logic [4:0] idx;
    idx = 5'h00;
    case (s)
      {STRAP_LOW, STRAP_OPEN, STRAP_LOW}: idx = 5'h00;
      {STRAP_LOW, STRAP_HIGH, STRAP_OPEN}: idx = 5'h01;
      {STRAP_LOW, STRAP_OPEN, STRAP_OPEN}: idx = 5'h02;
      {STRAP_LOW, STRAP_OPEN, STRAP_HIGH}: idx = 5'h03;
      {STRAP_LOW, STRAP_LOW, STRAP_LOW}: idx = 5'h04;
      {STRAP_LOW, STRAP_HIGH, STRAP_HIGH}: idx = 5'h05;
      {STRAP_LOW, STRAP_LOW, STRAP_OPEN}: idx = 5'h06;
      {STRAP_LOW, STRAP_LOW, STRAP_HIGH}: idx = 5'h07;
      {STRAP_OPEN, STRAP_OPEN, STRAP_LOW}: idx = 5'h08;
      {STRAP_OPEN, STRAP_HIGH, STRAP_OPEN}: idx = 5'h09;
      {STRAP_OPEN, STRAP_OPEN, STRAP_OPEN}: idx = 5'h0a;
      {STRAP_OPEN, STRAP_OPEN, STRAP_HIGH}: idx = 5'h0b;
      {STRAP_OPEN, STRAP_LOW, STRAP_LOW}: idx = 5'h0c;
      {STRAP_OPEN, STRAP_HIGH, STRAP_HIGH}: idx = 5'h0d;
      {STRAP_OPEN, STRAP_LOW, STRAP_OPEN}: idx = 5'h0e;
      {STRAP_OPEN, STRAP_LOW, STRAP_HIGH}: idx = 5'h0f;
      {STRAP_HIGH, STRAP_OPEN, STRAP_LOW}: idx = 5'h10;
      {STRAP_HIGH, STRAP_HIGH, STRAP_OPEN}: idx = 5'h11;
      {STRAP_HIGH, STRAP_OPEN, STRAP_OPEN}: idx = 5'h12;
      {STRAP_HIGH, STRAP_OPEN, STRAP_HIGH}: idx = 5'h13;
      {STRAP_HIGH, STRAP_LOW, STRAP_LOW}: idx = 5'h14;
      {STRAP_HIGH, STRAP_HIGH, STRAP_HIGH}: idx = 5'h15;
      {STRAP_HIGH, STRAP_LOW, STRAP_OPEN}: idx = 5'h16;
      {STRAP_HIGH, STRAP_LOW, STRAP_HIGH}: idx = 5'h17;
      {STRAP_LOW, STRAP_HIGH, STRAP_LOW}: idx = 5'h18;
      {STRAP_OPEN, STRAP_HIGH, STRAP_LOW}: idx = 5'h19;
      {STRAP_HIGH, STRAP_HIGH, STRAP_LOW}: idx = 5'h1a;
      default: idx = 5'h00;
    endcase
    return idx;
  endfunction

  assign addr_out = {ADDR_TOP, strap_index(strap_in)};

endmodule

// ===== verif/sba_master_model.sv
// Bus master model driving the two-wire clock and pulling the data line.
`timescale 1ns/100ps
module sba_master_model (
  // Clock.
  input wire logic ref_clk_in,
  // Resolved data line.
  input wire logic sda_in,
  // Bus clock and data pull-down.
  output logic scl_out,
  output logic sda_low_out
);
  // The bus clock stands high outside frames.
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  task automatic gap(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask

  // The short gaps keep a data change off the clock edge.
  // start condition
  task automatic start_cond();
    gap(2);
    sda_low_out = 1'b0;
    gap(4);
    scl_out = 1'b1;
    gap(4);
    sda_low_out = 1'b1;
    gap(4);
    scl_out = 1'b0;
    gap(4);
  endtask

  task automatic stop_cond();
    gap(2);
    sda_low_out = 1'b1;
    gap(4);
    scl_out = 1'b1;
    gap(4);
    sda_low_out = 1'b0;
    gap(8);
  endtask

  task automatic bit_io(input logic b, output logic r);
    gap(4);
    sda_low_out = !b;
    gap(4);
    scl_out = 1'b1;
    gap(4);
    r = sda_in;
    gap(4);
    scl_out = 1'b0;
  endtask

  // byte out, line released in the ack slot
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask

  // byte in, then ack or leave the line high
  task automatic read_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(!ack, r);
  endtask
endmodule

// ===== verif/test_smbus_slave_addressing_alert.sv
// Self-checking bench for the two-wire slave with strapped address and alert.
`timescale 1ns/100ps
module test_smbus_slave_addressing_alert;
  import sba_pkg::*;
  localparam logic [3:0] LOW_PAIR [8] = '{4'h8, 4'h6, 4'ha, 4'h9,
                                          4'h0, 4'h5, 4'h2, 4'h1};
  localparam logic [1:0] GRP [3] = '{2'h0, 2'h2, 2'h1};
  logic ref_clk_in, reset_in, scl, m_low, sda_o, sda_oe, sda_line;
  logic alert_o, alert_oe, mw_en;
  logic [1:0] s0, s1, s2;
  logic [5:0] faults, aen;
  sba_wr_type reg_wr;
  logic [2:0] rd_addr;
  logic [6:0] own_addr, own;
  logic [7:0] regs [8];
  logic [7:0] exp_regs [8];
  logic [10:0] last_wr;
  int wr_count, fail_count, n_compared, cyc, k, j, m, idx;

  assign sda_line = !(m_low | (sda_oe & !sda_o));

  sba_slave sba_slave_i (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_o), .sda_oe_out(sda_oe),
    .alert_out(alert_o), .alert_oe_out(alert_oe),
    .addr_select_pin_0_in(s0), .addr_select_pin_1_in(s1),
    .addr_select_pin_2_in(s2),
    .mass_write_enable_bit_in(mw_en),
    .fault_flags_in(faults), .alert_enable_in(aen),
    .reg_wr_out(reg_wr), .reg_rd_addr_out(rd_addr),
    .reg_rd_data_in(regs[rd_addr]), .own_addr_out(own_addr)
  );

  sba_master_model sba_master_model_i (
    .ref_clk_in(ref_clk_in), .sda_in(sda_line),
    .scl_out(scl), .sda_low_out(m_low)
  );

  always #25 ref_clk_in = ~ref_clk_in;

  // Register file behind the slave; write strobes are counted.
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (reg_wr.strobe === 1'b1) begin
      regs[reg_wr.addr] <= reg_wr.data;
      last_wr <= {reg_wr.addr, reg_wr.data};
      wr_count <= wr_count + 1;
    end
    if (cyc == 40000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Strap codes {pin 2, pin 1, pin 0} of each address index.
  function automatic logic [5:0] strap_of(input int i);
    logic [1:0] p2;
    logic [3:0] lo;
    p2 = GRP[(i < 24) ? i / 8 : i - 24];
    lo = (i < 24) ? LOW_PAIR[i % 8] : 4'h4;
    return {p2, lo};
  endfunction

  task automatic send_addr(input logic [6:0] a, input logic rw,
                           output logic ack);
    sba_master_model_i.start_cond();
    sba_master_model_i.write_byte({a, rw}, ack);
  endtask

  task automatic xfer_w(input logic [6:0] a, input logic [7:0] cmd,
                        input int nb, input logic exp_ack);
    logic ack;
    logic [7:0] d;
    int c0;
    d = $urandom;
    c0 = wr_count;
    send_addr(a, 1'b0, ack);
    chk(ack, exp_ack);
    if (ack) begin
      sba_master_model_i.write_byte(cmd, ack);
      chk(ack, 1'b1);
      for (int i = 0; i < nb; i++) begin
        sba_master_model_i.write_byte(i == 0 ? d : ~d, ack);
        chk(ack, 1'b1);
      end
    end
    sba_master_model_i.stop_cond();
    if (exp_ack) begin
      chk(rd_addr, cmd[2:0]);
      if (nb > 0) begin
        chk(last_wr, {cmd[2:0], d});
        exp_regs[cmd[2:0]] = d;
      end
    end
    chk(16'(wr_count - c0), (exp_ack && nb > 0) ? 16'h1 : 16'h0);
  endtask

  task automatic rd_reg(input logic [7:0] cmd, input logic word);
    logic ack;
    logic [7:0] d;
    send_addr(own, 1'b0, ack);
    sba_master_model_i.write_byte(cmd, ack);
    send_addr(own, 1'b1, ack);
    chk(ack, 1'b1);
    sba_master_model_i.read_byte(word, d);
    chk(d, exp_regs[cmd[2:0]]);
    if (word) begin
      sba_master_model_i.read_byte(1'b0, d);
      chk(d, exp_regs[cmd[2:0]]);
    end
    sba_master_model_i.stop_cond();
    chk(rd_addr, cmd[2:0]);
  endtask

  task automatic probe(input logic [6:0] a, input logic rw,
                       input logic exp_ack);
    logic ack;
    logic [7:0] d;
    send_addr(a, rw, ack);
    chk(ack, exp_ack);
    if (ack) begin
      sba_master_model_i.read_byte(1'b0, d);
      chk(d, {own, 1'b0});
    end
    sba_master_model_i.stop_cond();
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask

  initial begin
    ref_clk_in = 1'b0;
    reset_in = 1'b1;
    mw_en = 1'b1;
    faults = '0;
    aen = '0;
    {s2, s1, s0} = strap_of(0);
    cyc = 0;
    wr_count = 0;
    fail_count = 0;
    n_compared = 0;
    last_wr = '0;
    idx = $urandom(32'h856bb99d);
    for (int i = 0; i < 8; i++) begin
      regs[i] = $urandom;
      exp_regs[i] = regs[i];
    end
    settle(16);
    reset_in = 1'b0;
    settle(8);
    for (int i = 0; i < 27; i++) begin
      {s2, s1, s0} = strap_of(i);
      settle(4);
      chk(own_addr, {2'b10, 5'(i)});
    end
    $display("strap table done");
    idx = $urandom % 27;
    own = {2'b10, 5'(idx)};
    {s2, s1, s0} = strap_of(idx);
    settle(8);
    repeat (8) begin
      xfer_w(own, 8'($urandom), 1 + $urandom % 2, 1'b1);
      rd_reg(8'($urandom), 1'($urandom));
    end
    xfer_w(own ^ 7'h01, 8'h00, 1, 1'b0);
    $display("write and read done");
    xfer_w(MASS_WRITE_ADDR, 8'($urandom), 2, 1'b1);
    rd_reg({5'h1f, last_wr[10:8]}, 1'b0);
    probe(MASS_WRITE_ADDR, 1'b1, 1'b0);
    mw_en = 1'b0;
    xfer_w(MASS_WRITE_ADDR, 8'($urandom), 1, 1'b0);
    mw_en = 1'b1;
    $display("mass write done");
    k = $urandom % 6;
    j = (k + 1) % 6;
    m = (k + 2) % 6;
    aen = 6'h3f;
    aen[k] = 1'b0;
    faults[k] = 1'b1;
    settle(4);
    chk(alert_oe, 1'b0);
    probe(ALERT_RESP_ADDR, 1'b1, 1'b0);
    faults[j] = 1'b1;
    settle(4);
    chk(alert_oe, 1'b1);
    chk({sda_o, alert_o}, 16'h0000);
    probe(ALERT_RESP_ADDR, 1'b0, 1'b0);
    chk(alert_oe, 1'b1);
    probe(ALERT_RESP_ADDR, 1'b1, 1'b1);
    chk(alert_oe, 1'b0);
    settle(40);
    chk(alert_oe, 1'b0);
    faults[j] = 1'b0;
    settle(4);
    faults[j] = 1'b1;
    settle(4);
    chk(alert_oe, 1'b1);
    xfer_w(own, 8'($urandom), 0, 1'b1);
    chk(alert_oe, 1'b0);
    faults[m] = 1'b1;
    settle(4);
    chk(alert_oe, 1'b1);
    rd_reg(8'($urandom), 1'b1);
    chk(alert_oe, 1'b0);
    $display("alert done");
    end_sim();
  end
endmodule
